// ---- pkg/rtc_alarm_defs.vh ----
// Register map, field layout and reset values of the alarm and flag block
`ifndef RTC_ALARM_DEFS_VH
`define RTC_ALARM_DEFS_VH

// ==========================================================
// Register addresses
`define ADDR_SECOND_ALARM        3'h0
`define ADDR_MINUTE_ALARM        3'h1
`define ADDR_HOUR_ALARM          3'h2
`define ADDR_WEEKDAY_ALARM       3'h3
`define ADDR_DATE_ALARM          3'h4
`define ADDR_MONTH_ALARM         3'h5
`define ADDR_CLOCK_FLAG_CONTROL  3'h6

// ==========================================================
// Alarm register layout
`define ALARM_COUNT              6
`define COMPARE_ENABLE_BIT       7
`define VALUE_MASK_SECOND        7'h7f
`define VALUE_MASK_MINUTE        7'h7f
`define VALUE_MASK_HOUR          7'h3f
`define VALUE_MASK_WEEKDAY       7'h07
`define VALUE_MASK_DATE          7'h3f
`define VALUE_MASK_MONTH         7'h1f
`define COMPARE_ENABLE_RESET     1'h0

// ==========================================================
// Clock flag control layout
`define CARRY_FLAG_BIT           7
`define CARRY_IRQ_ENABLE_BIT     4
`define ALARM_IRQ_ENABLE_BIT     3
`define ALARM_FLAG_BIT           0
`define CONTROL_RESET            8'h00
`define CARRY_FLAG_RESET         1'h0
`define IRQ_ENABLE_RESET         1'h0
`define ALARM_FLAG_RESET         1'h0
`define READ_IDLE                8'h00

`endif

// ---- design/sync_two_stage.v ----
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps

module sync_two_stage (
	input  wire clock_i,
	input  wire rst_b_i,
	input  wire level_i,
	output wire level_o
);

	reg stage_a;
	reg stage_b;

	// ==========================================================
	// Synchroniser; resets to the inactive (high) level
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stage_a <= 1'h1;
			stage_b <= 1'h1;
		end else begin
			stage_a <= level_i;
			stage_b <= stage_a;
		end
	end

	assign level_o = stage_b;

endmodule // sync_two_stage

// ---- design/alarm_field_match.v ----
// Compare of one alarm field against its calendar counter
`timescale 1ns/10ps

module alarm_field_match (
	input  wire [6:0] value_i,
	input  wire [6:0] mask_i,
	input  wire       compare_enable_i,
	input  wire [7:0] counter_i,
	output wire       match_o
);

	// ==========================================================
	// A disabled field never blocks the alarm
	assign match_o = !compare_enable_i || ((counter_i[6:0] & mask_i) == (value_i & mask_i));

endmodule // alarm_field_match

// ---- design/rtc_alarm_flags.v ----
// Alarm registers, alarm compare, carry and alarm flags of the clock
`timescale 1ns/10ps
`include "rtc_alarm_defs.vh"

module rtc_alarm_flags (
	input  wire       CLOCK_I,
	input  wire       RST_B_I,
	input  wire       MANUAL_RST_B_I,
	input  wire [2:0] ADDR_I,
	input  wire [7:0] WDATA_I,
	input  wire       WR_I,
	input  wire       RD_I,
	output reg  [7:0] RDATA_O,
	input  wire [7:0] SECOND_COUNTER_I,
	input  wire [7:0] MINUTE_COUNTER_I,
	input  wire [7:0] HOUR_COUNTER_I,
	input  wire [7:0] WEEKDAY_COUNTER_I,
	input  wire [7:0] DATE_COUNTER_I,
	input  wire [7:0] MONTH_COUNTER_I,
	input  wire       SECOND_CARRY_I,
	input  wire       SUB_SECOND_CARRY_I,
	input  wire       COUNTER_READ_I,
	output reg        CARRY_IRQ_O,
	output reg        ALARM_IRQ_O
);

	// ==========================================================
	// Decoding shared by writes, reads and the compare
	function [6:0] field_mask;
		input [2:0] index;
		begin
			case (index)
				3'h0:    field_mask = `VALUE_MASK_SECOND;
				3'h1:    field_mask = `VALUE_MASK_MINUTE;
				3'h2:    field_mask = `VALUE_MASK_HOUR;
				3'h3:    field_mask = `VALUE_MASK_WEEKDAY;
				3'h4:    field_mask = `VALUE_MASK_DATE;
				3'h5:    field_mask = `VALUE_MASK_MONTH;
				default: field_mask = 7'h00;
			endcase
		end
	endfunction

	function is_alarm_addr;
		input [2:0] addr;
		begin
			is_alarm_addr = (addr <= `ADDR_MONTH_ALARM);
		end
	endfunction

	function [7:0] control_image;
		input carry;
		input carry_enable;
		input alarm_enable;
		input alarm;
		begin
			control_image = {carry, 2'h0, carry_enable, alarm_enable, 2'h0, alarm};
		end
	endfunction

	// ==========================================================
	// Storage
	reg  [6:0]  alarm_value [0:5];
	reg  [5:0]  compare_enable;
	reg         carry_flag;
	reg         carry_irq_enable;
	reg         alarm_irq_enable;
	reg         alarm_flag;
	reg  [47:0] last_counters;
	reg         last_valid;
	reg         next_carry_flag;
	reg         next_alarm_flag;
	reg  [7:0]  read_image;

	wire        manual_rst_b;
	wire        manual_reset_active;
	wire [47:0] counters;
	wire [5:0]  field_ok;
	wire [5:0]  field_changed;
	wire [5:0]  alarm_write;
	wire        control_write;
	wire        write_carry_flag;
	wire        write_carry_irq_enable;
	wire        write_alarm_irq_enable;
	wire        write_alarm_flag;
	wire        counters_changed;
	wire        all_fields_ok;
	wire        any_enable;
	wire        alarm_match;
	wire        alarm_hit;
	wire        any_carry;
	wire        carry_hit;
	wire        next_carry_irq;
	wire        next_alarm_irq;

	wire [7:0]  second_counter;
	wire [7:0]  minute_counter;
	wire [7:0]  hour_counter;
	wire [7:0]  weekday_counter;
	wire [7:0]  date_counter;
	wire [7:0]  month_counter;

	wire [7:0]  second_alarm;
	wire [7:0]  minute_alarm;
	wire [7:0]  hour_alarm;
	wire [7:0]  weekday_alarm;
	wire [7:0]  date_alarm;
	wire [7:0]  month_alarm;
	wire [7:0]  clock_flag_control;

	// ==========================================================
	// Calendar counter values; bit 7 of each never takes part in the compare
	// Counters share this clock, so they need no synchroniser
	assign second_counter  = SECOND_COUNTER_I;
	assign minute_counter  = MINUTE_COUNTER_I;
	assign hour_counter    = HOUR_COUNTER_I;
	assign weekday_counter = WEEKDAY_COUNTER_I;
	assign date_counter    = DATE_COUNTER_I;
	assign month_counter   = MONTH_COUNTER_I;
	assign counters = {month_counter, date_counter, weekday_counter,
	                   hour_counter, minute_counter, second_counter};

	// ==========================================================
	// Address decode; the unmapped address selects nothing
	assign alarm_write[0] = WR_I && (ADDR_I == `ADDR_SECOND_ALARM);
	assign alarm_write[1] = WR_I && (ADDR_I == `ADDR_MINUTE_ALARM);
	assign alarm_write[2] = WR_I && (ADDR_I == `ADDR_HOUR_ALARM);
	assign alarm_write[3] = WR_I && (ADDR_I == `ADDR_WEEKDAY_ALARM);
	assign alarm_write[4] = WR_I && (ADDR_I == `ADDR_DATE_ALARM);
	assign alarm_write[5] = WR_I && (ADDR_I == `ADDR_MONTH_ALARM);
	assign control_write  = WR_I && (ADDR_I == `ADDR_CLOCK_FLAG_CONTROL);

	// ==========================================================
	// Control write fields
	assign write_carry_flag       = WDATA_I[`CARRY_FLAG_BIT];
	assign write_carry_irq_enable = WDATA_I[`CARRY_IRQ_ENABLE_BIT];
	assign write_alarm_irq_enable = WDATA_I[`ALARM_IRQ_ENABLE_BIT];
	assign write_alarm_flag       = WDATA_I[`ALARM_FLAG_BIT];

	// ==========================================================
	// Manual reset comes from a pin
	sync_two_stage manual_sync (
		.clock_i (CLOCK_I),
		.rst_b_i (RST_B_I),
		.level_i (MANUAL_RST_B_I),
		.level_o (manual_rst_b)
	);

	// Low level on the pin clears the interrupt enables and the alarm flag while it lasts
	assign manual_reset_active = !manual_rst_b;

	// ==========================================================
	// Alarm values: no reset, kept through manual reset and standby
	genvar g;
	generate
		for (g = 0; g < `ALARM_COUNT; g = g + 1) begin : field
			localparam [2:0] field_index = g;

			always @(posedge CLOCK_I) begin
				if (alarm_write[g]) begin
					alarm_value[g] <= WDATA_I[6:0] & field_mask(field_index);
				end
			end

			// Any field that moves counts as a calendar change
			assign field_changed[g] = counters[g*8 +: 8] != last_counters[g*8 +: 8];

			alarm_field_match compare (
				.value_i          (alarm_value[g]),
				.mask_i           (field_mask(field_index)),
				.compare_enable_i (compare_enable[g]),
				.counter_i        (counters[g*8 +: 8]),
				.match_o          (field_ok[g])
			);
		end
	endgenerate

	// ==========================================================
	// Compare enables: cleared only by power-on reset
	always @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			compare_enable <= {6{`COMPARE_ENABLE_RESET}};
		end else if (WR_I && is_alarm_addr(ADDR_I)) begin
			compare_enable[ADDR_I] <= WDATA_I[`COMPARE_ENABLE_BIT];
		end
	end

	// ==========================================================
	// Alarm detection
	// Only a change of the calendar sets the flag, so a cleared flag is not
	// set again by the same unchanged time.
	always @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			last_counters <= 48'h0;
			last_valid    <= 1'h0;
		end else begin
			last_counters <= counters;
			last_valid    <= 1'h1;
		end
	end

	assign counters_changed = last_valid && (|field_changed);
	assign all_fields_ok    = &field_ok;
	assign any_enable       = |compare_enable;
	assign alarm_match      = all_fields_ok && any_enable;
	assign alarm_hit        = counters_changed && alarm_match;
	assign any_carry        = SECOND_CARRY_I || SUB_SECOND_CARRY_I;
	assign carry_hit        = COUNTER_READ_I && any_carry;

	// ==========================================================
	// Flag next values; a hardware set wins over a software clear
	always @* begin
		next_carry_flag = carry_flag;
		if (control_write) begin
			next_carry_flag = write_carry_flag;
		end
		if (carry_hit) begin
			next_carry_flag = 1'h1;
		end
	end

	// A written 1 leaves the alarm flag as it was
	always @* begin
		next_alarm_flag = alarm_flag;
		if (control_write && !write_alarm_flag) begin
			next_alarm_flag = 1'h0;
		end
		if (alarm_hit) begin
			next_alarm_flag = 1'h1;
		end
	end

	// ==========================================================
	// Carry flag: a manual reset leaves it as is; software must rewrite it
	always @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			carry_flag <= `CARRY_FLAG_RESET;
		end else if (!manual_reset_active) begin
			carry_flag <= next_carry_flag;
		end
	end

	// ==========================================================
	// Interrupt enables: cleared by either reset
	always @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			carry_irq_enable <= `IRQ_ENABLE_RESET;
			alarm_irq_enable <= `IRQ_ENABLE_RESET;
		end else if (manual_reset_active) begin
			carry_irq_enable <= `IRQ_ENABLE_RESET;
			alarm_irq_enable <= `IRQ_ENABLE_RESET;
		end else if (control_write) begin
			carry_irq_enable <= write_carry_irq_enable;
			alarm_irq_enable <= write_alarm_irq_enable;
		end
	end

	// ==========================================================
	// Alarm flag: cleared by either reset
	always @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			alarm_flag <= `ALARM_FLAG_RESET;
		end else if (manual_reset_active) begin
			alarm_flag <= `ALARM_FLAG_RESET;
		end else begin
			alarm_flag <= next_alarm_flag;
		end
	end

	// ==========================================================
	// Interrupt outputs, one cycle behind the flags
	assign next_carry_irq = carry_flag && carry_irq_enable;
	assign next_alarm_irq = alarm_flag && alarm_irq_enable;

	always @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CARRY_IRQ_O <= 1'h0;
			ALARM_IRQ_O <= 1'h0;
		end else begin
			CARRY_IRQ_O <= next_carry_irq;
			ALARM_IRQ_O <= next_alarm_irq;
		end
	end

	// ==========================================================
	// Register images; value bits are stored masked, so reserved bits read zero
	assign second_alarm       = {compare_enable[0], alarm_value[0]};
	assign minute_alarm       = {compare_enable[1], alarm_value[1]};
	assign hour_alarm         = {compare_enable[2], alarm_value[2]};
	assign weekday_alarm      = {compare_enable[3], alarm_value[3]};
	assign date_alarm         = {compare_enable[4], alarm_value[4]};
	assign month_alarm        = {compare_enable[5], alarm_value[5]};
	assign clock_flag_control = control_image(carry_flag, carry_irq_enable,
	                                          alarm_irq_enable, alarm_flag);

	// ==========================================================
	// Read select; choosing here keeps the read latency at one cycle
	always @* begin
		read_image = `READ_IDLE;
		case (ADDR_I)
			`ADDR_SECOND_ALARM:       read_image = second_alarm;
			`ADDR_MINUTE_ALARM:       read_image = minute_alarm;
			`ADDR_HOUR_ALARM:         read_image = hour_alarm;
			`ADDR_WEEKDAY_ALARM:      read_image = weekday_alarm;
			`ADDR_DATE_ALARM:         read_image = date_alarm;
			`ADDR_MONTH_ALARM:        read_image = month_alarm;
			`ADDR_CLOCK_FLAG_CONTROL: read_image = clock_flag_control;
			default:                  read_image = `READ_IDLE;
		endcase
	end

	// ==========================================================
	// Read port: data stand only in the cycle after the strobe
	// Flags may change between a read and a later write-back.
	always @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			RDATA_O <= `READ_IDLE;
		end else if (!RD_I) begin
			RDATA_O <= `READ_IDLE;
		end else begin
			RDATA_O <= read_image;
		end
	end

endmodule // rtc_alarm_flags

// ---- dv/rtc_alarm_flags_props.sv ----
// Port checker of the alarm and flag block
`timescale 1ns/10ps

module rtc_alarm_flags_props (
	input wire       CLOCK_I,
	input wire       RST_B_I,
	input wire [2:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire       WR_I,
	input wire       RD_I,
	input wire [7:0] RDATA_O,
	input wire       SECOND_CARRY_I,
	input wire       SUB_SECOND_CARRY_I,
	input wire       COUNTER_READ_I,
	input wire       CARRY_IRQ_O,
	input wire       ALARM_IRQ_O
);
	// ==========================================
	// Assertions
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	wire ctl_wr = WR_I && ADDR_I == 3'h6;
	wire ctl_rd = RD_I && ADDR_I == 3'h6;
	wire carry_ev = COUNTER_READ_I && (SECOND_CARRY_I || SUB_SECOND_CARRY_I);
	read_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data not idle");
	carry_irq_off_a: assert property (ctl_wr && !WDATA_I[4] |-> ##2 !CARRY_IRQ_O)
		else $error("carry irq while disabled");
	alarm_irq_off_a: assert property (ctl_wr && !WDATA_I[3] |-> ##2 !ALARM_IRQ_O)
		else $error("alarm irq while disabled");
	ctl_reserved_a: assert property (ctl_rd |=> RDATA_O[6:5] == 2'h0 && RDATA_O[2:1] == 2'h0)
		else $error("reserved control bits set");
	weekday_zero_a: assert property (RD_I && ADDR_I == 3'h3 |=> RDATA_O[6:3] == 4'h0)
		else $error("weekday reserved bits set");
	month_zero_a: assert property (RD_I && ADDR_I == 3'h5 |=> RDATA_O[6:5] == 2'h0)
		else $error("month reserved bits set");
	unmapped_read_a: assert property (RD_I && ADDR_I == 3'h7 |=> RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	carry_cause_a: assert property ($rose(CARRY_IRQ_O) |-> $past(WR_I, 2) || $past(carry_ev, 2))
		else $error("carry irq without cause");
	carry_set_a: assert property (carry_ev ##1 ctl_rd |=> RDATA_O[7])
		else $error("carry flag not set");
	carry_irq_c: cover property ($rose(CARRY_IRQ_O));
	alarm_irq_c: cover property ($rose(ALARM_IRQ_O));
	carry_read_c: cover property (carry_ev ##1 ctl_rd);
endmodule // rtc_alarm_flags_props

bind rtc_alarm_flags rtc_alarm_flags_props chk (.*);

// ---- dv/rtc_alarm_flags_test.sv ----
// Register level testbench of the alarm and flag block
`timescale 1ns/10ps

module rtc_alarm_flags_test;
	reg        CLOCK_I, RST_B_I, MANUAL_RST_B_I, WR_I, RD_I;
	reg  [2:0] ADDR_I, ev;
	reg  [7:0] WDATA_I, d;
	reg [47:0] cnt;
	wire [7:0] RDATA_O;
	wire       CARRY_IRQ_O, ALARM_IRQ_O;
	int        failures = 0, checked = 0, i;
	logic [7:0] rmask [6] = '{8'hff, 8'hff, 8'hbf, 8'h87, 8'hbf, 8'h9f};
	logic [7:0] aval [6] = '{8'hb0, 8'h95, 8'h23, 8'h00, 8'h01, 8'h01};
	logic [2:0] evs [3] = '{3'b110, 3'b101, 3'b010};

	rtc_alarm_flags dut (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .MANUAL_RST_B_I(MANUAL_RST_B_I),
		.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
		.SECOND_COUNTER_I(cnt[47:40]), .MINUTE_COUNTER_I(cnt[39:32]),
		.HOUR_COUNTER_I(cnt[31:24]), .WEEKDAY_COUNTER_I(cnt[23:16]),
		.DATE_COUNTER_I(cnt[15:8]), .MONTH_COUNTER_I(cnt[7:0]), .SECOND_CARRY_I(ev[1]),
		.SUB_SECOND_CARRY_I(ev[0]), .COUNTER_READ_I(ev[2]), .CARRY_IRQ_O(CARRY_IRQ_O),
		.ALARM_IRQ_O(ALARM_IRQ_O));

	// ==========================================
	// Clock and tasks
	initial begin
		CLOCK_I = 1'b0;
		forever #4 CLOCK_I = ~CLOCK_I;
	end
	task automatic finish_test;
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
		checked++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	// Gap cycle after each strobe keeps one assignment per signal per step
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		ADDR_I <= a;
		WDATA_I <= v;
		WR_I <= 1'b1;
		@(posedge CLOCK_I);
		WR_I <= 1'b0;
		@(posedge CLOCK_I);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLOCK_I);
		RD_I <= 1'b0;
		@(negedge CLOCK_I);
		v = RDATA_O;
		@(posedge CLOCK_I);
	endtask
	task automatic irq(input logic [1:0] e);
		@(negedge CLOCK_I);
		chk({6'h0, CARRY_IRQ_O, ALARM_IRQ_O}, {6'h0, e}, "irq");
		@(posedge CLOCK_I);
	endtask
	task automatic tick(input logic [47:0] v);
		cnt <= v;
		repeat (2) @(posedge CLOCK_I);
	endtask

	// ==========================================
	// Scenarios
	initial begin
		{RST_B_I, WR_I, RD_I, ADDR_I, WDATA_I, cnt, ev} = '0;
		MANUAL_RST_B_I = 1'b1;
		repeat (12) @(posedge CLOCK_I);
		RST_B_I <= 1'b1;
		@(posedge CLOCK_I);
		rd(3'h6, d); chk(d, 8'h00, "control");
		for (i = 0; i < 6; i++) begin
			rd(i[2:0], d); chk({d[7], 7'h0}, 8'h00, "enable");
			wr(i[2:0], 8'hff); rd(i[2:0], d); chk(d, rmask[i], "alarm");
		end
		wr(3'h7, 8'hff); rd(3'h7, d); chk(d, 8'h00, "unmapped");
		wr(3'h6, 8'h99); rd(3'h6, d); chk(d, 8'h98, "control");
		irq(2'b10);
		wr(3'h6, 8'h00); rd(3'h6, d); chk(d, 8'h00, "control");
		irq(2'b00);
		// A carry without a counter read must leave the flag alone
		for (i = 0; i < 3; i++) begin
			wr(3'h6, 8'h10);
			ev <= evs[i];
			@(posedge CLOCK_I);
			ev <= 3'b000;
			rd(3'h6, d); chk(d, {evs[i][2], 7'h10}, "carry");
			irq({evs[i][2], 1'b0});
		end
		for (i = 0; i < 6; i++) wr(i[2:0], aval[i]);
		wr(3'h6, 8'h08);
		tick(48'h29_15_07_02_10_04); irq(2'b00);
		tick(48'h30_16_07_02_10_04); irq(2'b00);
		tick(48'h30_15_11_02_10_04); irq(2'b01);
		rd(3'h6, d); chk(d, 8'h09, "control");
		wr(3'h6, 8'h09); rd(3'h6, d); chk(d, 8'h09, "control");
		wr(3'h6, 8'h00); irq(2'b00);
		rd(3'h6, d); chk(d, 8'h00, "control");
		tick(48'h29_15_11_02_10_04);
		tick(48'h30_15_11_02_10_04); irq(2'b00);
		rd(3'h6, d); chk(d, 8'h01, "control");
		for (i = 0; i < 6; i++) wr(i[2:0], 8'h45);
		wr(3'h6, 8'h08);
		tick(48'h45_45_11_02_10_04); irq(2'b00);
		wr(3'h6, 8'h98);
		MANUAL_RST_B_I <= 1'b0;
		repeat (4) @(posedge CLOCK_I);
		MANUAL_RST_B_I <= 1'b1;
		repeat (4) @(posedge CLOCK_I);
		rd(3'h6, d); chk(d & 8'h7f, 8'h00, "control");
		irq(2'b00);
		wr(3'h6, 8'h00); rd(3'h6, d); chk(d, 8'h00, "control");
		rd(3'h0, d); chk(d, 8'h45, "alarm");
		finish_test;
	end
	// Run needs well under 2000 cycles
	initial begin
		#20000;
		failures++;
		finish_test;
	end
endmodule // rtc_alarm_flags_test
